/* pkg/pwts_defines.vh */
// Register offsets, field positions, reset values and codes for the timebase/shutdown block.
`ifndef PWTS_DEFINES_VH
`define PWTS_DEFINES_VH
`define PWTS_ADDR_TSEL      2'h0
`define PWTS_ADDR_ASHUT     2'h1
`define PWTS_TSEL_RESET     8'h00
`define PWTS_TBF_RESET      2'h0
`define PWTS_ASHUT_RESET    8'h00
`define PWTS_ASE_BIT        7
`define PWTS_SRC_HI         6
`define PWTS_SRC_LO         4
`define PWTS_PAC_HI         3
`define PWTS_PAC_LO         2
`define PWTS_PBD_HI         1
`define PWTS_PBD_LO         0
`define PWTS_TB_TMR2        2'h0
`define PWTS_TB_TMR4        2'h1
`define PWTS_TB_TMR6        2'h2
`define PWTS_SS_LOW         2'h0
`define PWTS_SS_HIGH        2'h1
`endif

/* core/pwts_sync2.v */
// Two-flip-flop synchroniser for a bus of asynchronous levels.
`timescale 1ns/1ps
module pwts_sync2 #(
	parameter W = 1
) (
	// Clock and reset.
	input  wire         clk_i,
	input  wire         rst_n_i,
	// Level in and synchronised level out.
	input  wire [W-1:0] d_i,
	output wire [W-1:0] q_o
);
	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;

	// The first stage feeds only the second, so metastability cannot spread.
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_ff <= {W{1'b0}};
			sync_ff <= {W{1'b0}};
		end
		else
		begin
			meta_ff <= d_i;
			sync_ff <= meta_ff;
		end
	end

	assign q_o = sync_ff;
endmodule

/* core/pwts_top.v */
// Timebase select and auto-shutdown control for PWM channel five.
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "pwts_defines.vh"
module pwts_top (
	// Clock and reset.
	input  wire        clk_i,
	input  wire        rst_n_i,
	// Avalon-MM slave.
	input  wire [1:0]  avs_address_i,
	input  wire        avs_read_i,
	input  wire        avs_write_i,
	input  wire [31:0] avs_writedata_i,
	output reg  [31:0] avs_readdata_o,
	output wire        avs_waitrequest_o,
	// Timer period ticks, on this clock.
	input  wire        tmr2_tick_i,
	input  wire        tmr4_tick_i,
	input  wire        tmr6_tick_i,
	input  wire        tmr1_tick_i,
	// Asynchronous event sources and the comparator sync enable.
	input  wire        cmp1_out_i,
	input  wire        cmp2_out_i,
	input  wire        int_pin_i,
	input  wire        comparator_sync_enable_i,
	// PWM drive from the channel engine.
	input  wire [1:0]  pwm_ac_i,
	input  wire [1:0]  pwm_bd_i,
	// Selected timebase, pin outputs and shutdown status.
	output reg         channel_five_tick_o,
	output reg  [1:0]  channel_five_tsel_o,
	output reg  [1:0]  pin_ac_o,
	output reg  [1:0]  pin_ac_oe_o,
	output reg  [1:0]  pin_bd_o,
	output reg  [1:0]  pin_bd_oe_o,
	output wire        shutdown_event_status_o
);
	reg        rst_meta_ff;
	reg        rst_sync_ff;
	wire       rst_n;
	reg  [1:0] channel5_timebase_field_ff;
	reg  [2:0] src_ff;
	reg  [1:0] pair_ac_shutdown_state_ff;
	reg  [1:0] pair_bd_shutdown_state_ff;
	reg        shutdown_event_status_ff;
	reg        cmp_pend_ff;
	reg        ack_ff;
	wire [3:0] sync_w;
	wire       cmp1_low;
	wire       cmp2_low;
	wire       pin_low;
	wire       sync_en;
	reg        cmp_hit;
	wire       cmp_fire;
	wire       pin_hit;
	wire       event_w;
	wire       wr_ashut;
	reg  [1:0] nxt_pin_ac;
	reg  [1:0] nxt_pin_ac_oe;
	reg  [1:0] nxt_pin_bd;
	reg  [1:0] nxt_pin_bd_oe;

	// Reset is asserted at once and released through two flip-flops.
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end
		else
		begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end
	assign rst_n = rst_sync_ff;

	// Comparator and pin levels come from outside this clock domain.
	pwts_sync2 #(
		.W (4)
	) u_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n),
		.d_i     ({comparator_sync_enable_i, int_pin_i, cmp2_out_i, cmp1_out_i}),
		.q_o     (sync_w)
	);
	assign cmp1_low = ~sync_w[0];
	assign cmp2_low = ~sync_w[1];
	assign pin_low  = ~sync_w[2];
	assign sync_en  = sync_w[3];

	// Source decode: bit 2 adds the pin, low bits choose the comparators.
	always @*
	begin
		case (src_ff[1:0])
			2'h1:    cmp_hit = cmp1_low;
			2'h2:    cmp_hit = cmp2_low;
			2'h3:    cmp_hit = cmp1_low | cmp2_low;
			default: cmp_hit = 1'b0;
		endcase
	end
	assign pin_hit = src_ff[2] & pin_low;

	// A synced comparator event waits for the next timer 1 tick before acting.
	always @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			cmp_pend_ff <= 1'b0;
		else if (!sync_en || tmr1_tick_i)
			cmp_pend_ff <= 1'b0;
		else if (cmp_hit)
			cmp_pend_ff <= 1'b1;
	end
	assign cmp_fire = sync_en ? ((cmp_hit | cmp_pend_ff) & tmr1_tick_i) : cmp_hit;
	assign event_w  = cmp_fire | pin_hit;

	// Bus: single-cycle wait on reads so data is registered; writes take at once.
	always @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			ack_ff <= 1'b0;
		else
			ack_ff <= avs_read_i & ~ack_ff;
	end
	assign avs_waitrequest_o = avs_read_i & ~ack_ff;
	assign wr_ashut = avs_write_i && (avs_address_i == `PWTS_ADDR_ASHUT);

	// Register writes; a shutdown event outranks a software clear of the status.
	always @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			channel5_timebase_field_ff <= `PWTS_TBF_RESET;
			src_ff                     <= 3'h0;
			pair_ac_shutdown_state_ff  <= 2'h0;
			pair_bd_shutdown_state_ff  <= 2'h0;
			shutdown_event_status_ff   <= 1'b0;
		end
		else
		begin
			if (avs_write_i && (avs_address_i == `PWTS_ADDR_TSEL))
				channel5_timebase_field_ff <= avs_writedata_i[1:0];
			if (wr_ashut)
			begin
				src_ff <= avs_writedata_i[`PWTS_SRC_HI:`PWTS_SRC_LO];
				pair_ac_shutdown_state_ff <= avs_writedata_i[`PWTS_PAC_HI:`PWTS_PAC_LO];
				pair_bd_shutdown_state_ff <= avs_writedata_i[`PWTS_PBD_HI:`PWTS_PBD_LO];
			end
			if (event_w)
				shutdown_event_status_ff <= 1'b1;
			else if (wr_ashut)
				shutdown_event_status_ff <= avs_writedata_i[`PWTS_ASE_BIT];
		end
	end
	assign shutdown_event_status_o = shutdown_event_status_ff;

	// Read data registered in the cycle that waitrequest is high.
	always @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			avs_readdata_o <= 32'h00000000;
		else if (avs_read_i && !ack_ff)
		begin
			if (avs_address_i == `PWTS_ADDR_TSEL)
				avs_readdata_o <= {30'h00000000, channel5_timebase_field_ff};
			else if (avs_address_i == `PWTS_ADDR_ASHUT)
				avs_readdata_o <= {24'h000000, shutdown_event_status_ff, src_ff,
					pair_ac_shutdown_state_ff, pair_bd_shutdown_state_ff};
			else
				avs_readdata_o <= 32'h00000000;
		end
	end

	// Timebase mux; the reserved code selects no timer so no edge is given.
	always @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			channel_five_tick_o <= 1'b0;
			channel_five_tsel_o <= 2'h0;
		end
		else
		begin
			channel_five_tsel_o <= channel5_timebase_field_ff;
			case (channel5_timebase_field_ff)
				`PWTS_TB_TMR2: channel_five_tick_o <= tmr2_tick_i;
				`PWTS_TB_TMR4: channel_five_tick_o <= tmr4_tick_i;
				`PWTS_TB_TMR6: channel_five_tick_o <= tmr6_tick_i;
				default:       channel_five_tick_o <= 1'b0;
			endcase
		end
	end

	// Pin drive: shutdown state per pair while the status bit stands.
	always @*
	begin
		nxt_pin_ac    = pwm_ac_i;
		nxt_pin_ac_oe = 2'h3;
		nxt_pin_bd    = pwm_bd_i;
		nxt_pin_bd_oe = 2'h3;
		if (shutdown_event_status_ff)
		begin
			nxt_pin_ac    = (pair_ac_shutdown_state_ff == `PWTS_SS_HIGH) ? 2'h3 : 2'h0;
			nxt_pin_ac_oe = pair_ac_shutdown_state_ff[1] ? 2'h0 : 2'h3;
			nxt_pin_bd    = (pair_bd_shutdown_state_ff == `PWTS_SS_HIGH) ? 2'h3 : 2'h0;
			nxt_pin_bd_oe = pair_bd_shutdown_state_ff[1] ? 2'h0 : 2'h3;
		end
	end

	// Pins are registered to keep glitches off the board.
	always @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_ac_o    <= 2'h0;
			pin_ac_oe_o <= 2'h0;
			pin_bd_o    <= 2'h0;
			pin_bd_oe_o <= 2'h0;
		end
		else
		begin
			pin_ac_o    <= nxt_pin_ac;
			pin_ac_oe_o <= nxt_pin_ac_oe;
			pin_bd_o    <= nxt_pin_bd;
			pin_bd_oe_o <= nxt_pin_bd_oe;
		end
	end
endmodule

/* dv/pwts_monitor.sv */
// Port checker for the timebase select and shutdown block.
`timescale 1ns/1ps
module pwts_monitor (
	// Clock, reset and bus.
	input logic        clk_i,
	input logic        rst_n_i,
	input logic [1:0]  avs_address_i,
	input logic        avs_read_i,
	input logic        avs_write_i,
	input logic [31:0] avs_readdata_o,
	input logic        avs_waitrequest_o,
	// Ticks, selection and pins.
	input logic        tmr2_tick_i,
	input logic        tmr4_tick_i,
	input logic        tmr6_tick_i,
	input logic [1:0]  pwm_ac_i,
	input logic        channel_five_tick_o,
	input logic [1:0]  channel_five_tsel_o,
	input logic [1:0]  pin_ac_o,
	input logic [1:0]  pin_ac_oe_o,
	input logic        shutdown_event_status_o
);
	// Edges since release; pins lag the internal reset copy.
	logic [1:0] up_ff;
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			up_ff <= 2'h0;
		else if (up_ff != 2'h3)
			up_ff <= up_ff + 2'h1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_tick_timer2: assert property (tmr2_tick_i |=> channel_five_tsel_o != 2'h0 ||
		channel_five_tick_o) else $error("Timer 2 tick lost.");
	a_tick_timer4: assert property (tmr4_tick_i |=> channel_five_tsel_o != 2'h1 ||
		channel_five_tick_o) else $error("Timer 4 tick lost.");
	a_tick_timer6: assert property (tmr6_tick_i |=> channel_five_tsel_o != 2'h2 ||
		channel_five_tick_o) else $error("Timer 6 tick lost.");
	a_tick_has_cause: assert property (channel_five_tick_o |->
		$past(tmr2_tick_i) && channel_five_tsel_o == 2'h0 ||
		$past(tmr4_tick_i) && channel_five_tsel_o == 2'h1 ||
		$past(tmr6_tick_i) && channel_five_tsel_o == 2'h2) else $error("Stray tick.");
	a_read_waits: assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1
		!avs_waitrequest_o) else $error("Read wait state wrong.");
	a_write_nowait: assert property (avs_write_i |-> !avs_waitrequest_o)
		else $error("Write stalled.");
	a_read_zero_bits: assert property (avs_read_i && !avs_waitrequest_o |->
		avs_readdata_o[31:8] == 24'h0 && (avs_address_i != 2'h0 ||
		avs_readdata_o[7:2] == 6'h0)) else $error("Unused read bits set.");
	a_pins_normal: assert property (up_ff == 2'h3 && !shutdown_event_status_o &&
		!$past(shutdown_event_status_o) |-> pin_ac_o == $past(pwm_ac_i) &&
		pin_ac_oe_o == 2'h3) else $error("Pins not following drive.");
	cover property ($rose(shutdown_event_status_o));
	cover property (channel_five_tick_o && channel_five_tsel_o == 2'h2);
	cover property (avs_read_i && !avs_waitrequest_o && avs_address_i == 2'h1);
endmodule
bind pwts_top pwts_monitor u_mon (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
	.tmr2_tick_i(tmr2_tick_i), .tmr4_tick_i(tmr4_tick_i), .tmr6_tick_i(tmr6_tick_i),
	.pwm_ac_i(pwm_ac_i), .channel_five_tick_o(channel_five_tick_o),
	.channel_five_tsel_o(channel_five_tsel_o), .pin_ac_o(pin_ac_o),
	.pin_ac_oe_o(pin_ac_oe_o), .shutdown_event_status_o(shutdown_event_status_o));

/* dv/pwts_top_tb.sv */
// Self-checking bench for the timebase select and shutdown block.
`timescale 1ns/1ps
module pwts_top_tb;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [1:0]  adr = 2'h0;
	logic        rd_s = 1'b0;
	logic        wr_s = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [2:0]  tk = 3'h0;
	logic        t1 = 1'b0;
	logic [2:0]  ev = 3'h7;
	logic        sy = 1'b0;
	logic [1:0]  pa = 2'h2;
	logic [31:0] rdata;
	logic [31:0] got;
	logic        wreq;
	logic        c5t;
	logic        sts;
	logic [1:0]  tsel, pac, paoe, pbd, pboe;
	int          err_total = 0;
	int          check_count = 0;
	int          i, j;
	always #2 clk_i = ~clk_i;
	pwts_top uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr),
		.avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wd),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .tmr2_tick_i(tk[0]),
		.tmr4_tick_i(tk[1]), .tmr6_tick_i(tk[2]), .tmr1_tick_i(t1), .cmp1_out_i(ev[0]),
		.cmp2_out_i(ev[1]), .int_pin_i(ev[2]), .comparator_sync_enable_i(sy),
		.pwm_ac_i(pa), .pwm_bd_i(2'h1), .channel_five_tick_o(c5t),
		.channel_five_tsel_o(tsel), .pin_ac_o(pac), .pin_ac_oe_o(paoe), .pin_bd_o(pbd),
		.pin_bd_oe_o(pboe), .shutdown_event_status_o(sts));
	// Compares one result and counts it.
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e)
		begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic final_report;
		$display("checks=%0d errors=%0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// One bus cycle; the request stands until waitrequest is seen low at a rising edge.
	task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		adr <= a;
		wd <= {24'h0, d};
		wr_s <= w;
		rd_s <= ~w;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wreq !== 1'b0 && n < 20);
		if (wreq !== 1'b0)
		begin
			err_total++;
			final_report();
		end
		// Data and waitrequest are the values that stood at this edge.
		got = rdata;
		wr_s <= 1'b0;
		rd_s <= 1'b0;
	endtask
	task automatic rchk(input logic [1:0] a, input logic [31:0] e);
		bus(1'b0, a, 8'h00);
		chk(got, e);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// Main sequence; the sync input is set well before events so its own lag is covered.
	initial
	begin
		cyc(10);
		rst_n_i <= 1'b1;
		cyc(3);
		rchk(2'h0, 32'h0);
		rchk(2'h1, 32'h0);
		bus(1'b1, 2'h0, 8'hFF);
		rchk(2'h0, 32'h3);
		bus(1'b1, 2'h2, 8'hFF);
		rchk(2'h2, 32'h0);
		for (i = 0; i < 4; i++)
			for (j = 0; j < 3; j++)
			begin
				bus(1'b1, 2'h0, i[7:0]);
				tk <= 3'h1 << j;
				pa <= i[1:0];
				@(posedge clk_i);
				tk <= 3'h0;
				#1 chk({31'h0, c5t}, {31'h0, i == j});
				chk({30'h0, pac}, {30'h0, i[1:0]});
			end
		pa <= 2'h2;
		for (i = 0; i < 8; i++)
			for (j = 0; j < 3; j++)
			begin
				bus(1'b1, 2'h1, {1'b0, i[2:0], 4'h6});
				ev <= ~(3'h1 << j);
				cyc(8);
				chk({31'h0, sts}, {31'h0, i[j]});
				ev <= 3'h7;
				cyc(8);
			end
		bus(1'b1, 2'h1, 8'h16);
		ev <= 3'h6;
		cyc(8);
		chk({26'h0, paoe, pac, pboe}, 32'h3C);
		bus(1'b1, 2'h1, 8'h16);
		rchk(2'h1, 32'h96);
		ev <= 3'h7;
		cyc(8);
		bus(1'b1, 2'h1, 8'h16);
		cyc(3);
		chk({24'h0, paoe, pac, pboe, pbd}, 32'hED);
		sy <= 1'b1;
		cyc(4);
		ev <= 3'h6;
		cyc(10);
		chk({31'h0, sts}, 32'h0);
		t1 <= 1'b1;
		@(posedge clk_i);
		t1 <= 1'b0;
		cyc(3);
		chk({31'h0, sts}, 32'h1);
		bus(1'b1, 2'h1, 8'h83);
		cyc(2);
		chk({24'h0, paoe, pac, pboe, pbd}, 32'hC0);
		bus(1'b1, 2'h0, 8'h02);
		rst_n_i <= 1'b0;
		cyc(2);
		rst_n_i <= 1'b1;
		cyc(3);
		rchk(2'h0, 32'h0);
		rchk(2'h1, 32'h0);
		final_report();
	end
endmodule
